// ===== sim/bstap_chk.sv
// Concurrent checks on the scan port and ball outputs.
// Assumes the ports of bstap_top; attached by the bind below.
`timescale 1ns/1ps

module bstap_chk
    import bstap_sim_pkg::*;
#(
    parameter int N_CELLS = 113
) (
    input wire logic               sys_clk,
    input wire logic               rst_n,
    input wire logic               tck,
    input wire logic               tms,
    input wire logic               tdo,
    input wire logic               tdo_oe,
    input wire logic [N_CELLS-1:0] core_out,
    input wire logic [N_CELLS-1:0] core_oe,
    input wire logic [N_CELLS-1:0] pad_out,
    input wire logic [N_CELLS-1:0] pad_oe
);

    // ----------------------------------------------------------------
    // Scan port
    // ----------------------------------------------------------------
    property p_tdo_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (tck && $past(tck)) |-> $stable(tdo) && $stable(tdo_oe);
    endproperty
    a_tdo_hold: assert property (p_tdo_hold)
        else $error("tdo moved while tck high");

    property p_oe_need_low;
        @(posedge tck) disable iff (!rst_n) tdo_oe |-> !$past(tms);
    endproperty
    a_oe_need_low: assert property (p_oe_need_low)
        else $error("tdo driven outside a shift state");

    property p_oe_stay;
        @(posedge tck) disable iff (!rst_n)
        $past(tdo_oe) && !$past(tms) |-> tdo_oe;
    endproperty
    a_oe_stay: assert property (p_oe_stay)
        else $error("tdo released while still shifting");

    property p_oe_fall;
        @(posedge tck) disable iff (!rst_n) $fell(tdo_oe) |-> $past(tms);
    endproperty
    a_oe_fall: assert property (p_oe_fall)
        else $error("shift left without tms high");

    // ----------------------------------------------------------------
    // Ball outputs
    // ----------------------------------------------------------------
    property p_nondrive_normal;
        @(posedge sys_clk) disable iff (!rst_n)
        (pad_oe & ~DRV_MASK) != '0 |->
            pad_oe == $past(core_oe) && pad_out == $past(core_out);
    endproperty
    a_nondrive_normal: assert property (p_nondrive_normal)
        else $error("non-drive cell enabled outside normal mode");

    property p_chain_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        pad_oe == DRV_MASK && $past(core_oe) != DRV_MASK |->
            (pad_out & ~DRV_MASK) == '0;
    endproperty
    a_chain_zero: assert property (p_chain_zero)
        else $error("non-drive cell value in chain mode");

    property p_highz_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        pad_oe == '0 && $past(core_oe) != '0 |-> pad_out == '0;
    endproperty
    a_highz_zero: assert property (p_highz_zero)
        else $error("ball value while all disabled");

    property p_reset_follow;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> ##1
            pad_oe == $past(core_oe) && pad_out == $past(core_out);
    endproperty
    a_reset_follow: assert property (p_reset_follow)
        else $error("balls not in normal mode after reset");

endmodule : bstap_chk

bind bstap_top bstap_chk #(.N_CELLS(N_CELLS)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdo(tdo),
    .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe),
    .pad_out(pad_out), .pad_oe(pad_oe));

// ===== sim/bstap_host.sv
// Board tester model: drives tck, tms and tdi one frame at a time.
// Assumes callers start a frame just after a sys_clk edge.
`timescale 1ns/1ps

module bstap_host (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // ----------------------------------------------------------------
    // Frame
    // ----------------------------------------------------------------
    // The odd start offset keeps tck edges off the sys_clk edges.
    // Lines change just after the falling edge, tdo is taken at rising.
    task automatic scan(input logic [127:0] tms_v,
                        input logic [127:0] tdi_v,
                        input int n,
                        output logic [127:0] tdo_v);
        tdo_v = '0;
        #3.3;
        for (int k = 0; k < n; k++) begin
            tms = tms_v[k];
            tdi = tdi_v[k];
            #80 tck = 1'b1;
            tdo_v[k] = tdo;
            #80 tck = 1'b0;
        end
        tdi = ~tdi; // No pull on tdi, so a released line flips.
    endtask : scan

endmodule : bstap_host

// ===== sim/bstap_sim_pkg.sv
// Patterns and the ball drive mask shared by the scan bench files.
// Assumes the chain has 113 cells, index 0 leaving first.
package bstap_sim_pkg;

    // ----------------------------------------------------------------
    // Stimulus patterns and drive mask
    // ----------------------------------------------------------------
    localparam logic [127:0] PRE  = {8{16'h96e1}};
    localparam logic [127:0] RING = {8{16'h3c5a}};
    localparam logic [127:0] COUT = {8{16'ha5c3}};
    localparam logic [127:0] COE  = {8{16'h0ff1}};

    // Worked out from ball pairs; never borrowed from design code.
    function automatic logic [112:0] drv_mask();
        drv_mask = '0;
        for (int i = 10; i <= 103; i++) begin
            if ((i % 2 == 0 && i <= 26 && i != 18) ||
                (i % 2 == 1 && i >= 29 && !(i >= 49 && i <= 65) &&
                 i != 75)) begin
                drv_mask[i] = 1'b1;
            end
        end
    endfunction : drv_mask

    localparam logic [112:0] DRV_MASK = drv_mask();

endpackage : bstap_sim_pkg

// ===== sim/bstap_tb_top.sv
// Self-checking bench for the TAP logic, one task per scenario.
// Assumes bstap_host drives the scan port; clk_en is held high.
`timescale 1ns/1ps

module bstap_tb_top;
    import bstap_pkg::*;
    import bstap_sim_pkg::*;

    localparam logic [3:0]  T_REV = 4'h6;     // Arbitrary value.
    localparam logic [15:0] T_DEV = 16'h1234; // Arbitrary value.
    localparam logic [10:0] T_VEN = 11'h155;  // Arbitrary value.

    logic         sys_clk, rst_n, clk_en, tck, tms, tdi, tdo, tdo_oe;
    logic [112:0] ring_in, core_out, core_oe, pad_out, pad_oe;
    logic [127:0] d;
    int           errors = 0;
    int           samples_checked = 0;

    bstap_top #(.ID_REV(T_REV), .ID_DEV(T_DEV), .ID_VENDOR(T_VEN)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .ring_in(ring_in), .core_out(core_out), .core_oe(core_oe),
        .pad_out(pad_out), .pad_oe(pad_oe));

    bstap_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [127:0] seen,
                         input logic [127:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    // From idle: load a code, expect the fixed capture pattern out.
    task automatic ir_load(input logic [7:0] code);
        logic [127:0] cap;
        @(posedge sys_clk);
        u_host.scan(128'h1803, {120'h0, code} << 4, 14, cap);
        check("ir capture", cap[11:4], IR_CAPTURE);
    endtask : ir_load

    // From idle: capture, shift n bits, update, back to idle.
    task automatic dr_scan(input int n, input logic [127:0] din);
        @(posedge sys_clk);
        u_host.scan(128'h1 | (128'h3 << (n + 2)), din << 3, n + 5, d);
        d = d >> 3;
    endtask : dr_scan

    // The ball path crosses domains, so give it a generous settle.
    task automatic check_pads(input logic [112:0] oe, out);
        repeat (30) @(posedge sys_clk);
        check("pad_oe", pad_oe, oe);
        check("pad_out", pad_out, out);
    endtask : check_pads

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_sample();
        ir_load(INS_SAMPLE);
        dr_scan(113, PRE);
        check("sample", d[112:0], RING[112:0]);
        check_pads(COE[112:0], COUT[112:0]);
        $display("Test sample done");
    endtask : t_sample

    task automatic t_extest();
        ir_load(INS_EXTEST);
        check_pads(DRV_MASK, PRE[112:0] & DRV_MASK);
        dr_scan(113, PRE);
        check("extest", d[112:0], RING[112:0]);
        $display("Test extest done");
    endtask : t_extest

    task automatic t_bypass();
        logic [7:0] codes [5] = '{INS_BYPASS, INS_CLAMP, INS_HIGHZ,
                                  8'h5a, 8'h80};
        foreach (codes[i]) begin
            ir_load(codes[i]);
            dr_scan(8, 128'hb4);
            check("bypass", d[7:0], 8'h68);
            if (codes[i] == INS_CLAMP) begin
                check_pads(DRV_MASK, PRE[112:0] & DRV_MASK);
            end else if (codes[i] == INS_HIGHZ) begin
                check_pads('0, '0);
            end else begin
                check_pads(COE[112:0], COUT[112:0]);
            end
        end
        $display("Test bypass done");
    endtask : t_bypass

    task automatic t_idcode();
        ir_load(INS_BYPASS);
        @(posedge sys_clk);
        u_host.scan(128'h1f, '0, 6, d);
        dr_scan(32, '0);
        check("id", d[31:0], {T_REV, T_DEV, T_VEN, 1'b1});
        ir_load(INS_IDCODE);
        dr_scan(32, '0);
        check("id", d[31:0], {T_REV, T_DEV, T_VEN, 1'b1});
        check_pads(COE[112:0], COUT[112:0]);
        $display("Test idcode done");
    endtask : t_idcode

    // ----------------------------------------------------------------
    // Clock, reset and sequence
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Reset is held over five tck pulses so the tck side sees it.
    initial begin
        rst_n <= 1'b0;
        clk_en <= 1'b1;
        ring_in <= RING[112:0];
        core_out <= COUT[112:0];
        core_oe <= COE[112:0];
        u_host.scan(128'h1f, '0, 5, d);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        u_host.scan(128'h7, '0, 4, d);
        t_sample();
        t_extest();
        t_bypass();
        t_idcode();
        print_verdict();
    end

    // About 100 us of traffic is expected; four times that is a hang.
    initial begin
        #400000;
        errors++;
        print_verdict();
    end

endmodule : bstap_tb_top

// ===== verilog/bstap_pkg.sv
// Constants and types shared by the boundary-scan test access port logic.
// Assumes the importing module sizes its chains from the widths here.
package bstap_pkg;

    // -----------------------------------------------------------------
    // Register sizes
    // -----------------------------------------------------------------
    localparam int IR_W    = 8;
    localparam int ID_W    = 32;
    localparam int BSR_LEN = 113;

    // -----------------------------------------------------------------
    // Instruction codes and the fixed capture pattern
    // -----------------------------------------------------------------
    localparam logic [7:0] INS_EXTEST  = 8'h00;
    localparam logic [7:0] INS_IDCODE  = 8'h21;
    localparam logic [7:0] INS_SAMPLE  = 8'h05;
    localparam logic [7:0] INS_CLAMP   = 8'h07;
    localparam logic [7:0] INS_HIGHZ   = 8'h03;
    localparam logic [7:0] INS_BYPASS  = 8'hff;
    localparam logic [7:0] IR_CAPTURE  = 8'h01;
    localparam logic [7:0] IR_RESET    = INS_IDCODE;

    // -----------------------------------------------------------------
    // Identification register field positions
    // -----------------------------------------------------------------
    localparam int ID_REV_LSB = 28;
    localparam int ID_DEV_LSB = 12;
    localparam int ID_VEN_LSB = 1;
    localparam logic ID_PRESENT = 1'b1;

    // -----------------------------------------------------------------
    // Types
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        BSTAP_SEL_BYPASS,
        BSTAP_SEL_ID,
        BSTAP_SEL_BSR
    } bstap_sel_t;

    typedef enum logic [3:0] {
        BSTAP_TLR, BSTAP_RTI,
        BSTAP_SEL_DR, BSTAP_CAP_DR, BSTAP_SH_DR, BSTAP_EX1_DR,
        BSTAP_PA_DR, BSTAP_EX2_DR, BSTAP_UPD_DR,
        BSTAP_SEL_IR, BSTAP_CAP_IR, BSTAP_SH_IR, BSTAP_EX1_IR,
        BSTAP_PA_IR, BSTAP_EX2_IR, BSTAP_UPD_IR
    } bstap_state_t;

    // Cells that drive a ball: the second cell of every two-cell ball.
    // Index 0 is the cell that leaves the chain first.
    function automatic logic [BSR_LEN-1:0] bstap_drive_mask();
        logic [BSR_LEN-1:0] m;
        m = '0;
        for (int i = 10; i <= 26; i += 2) begin
            if (i != 18) begin
                m[i] = 1'b1;
            end
        end
        for (int i = 29; i <= 47; i += 2) begin
            m[i] = 1'b1;
        end
        for (int i = 67; i <= 73; i += 2) begin
            m[i] = 1'b1;
        end
        for (int i = 77; i <= 103; i += 2) begin
            m[i] = 1'b1;
        end
        return m;
    endfunction : bstap_drive_mask

endpackage : bstap_pkg

// ===== verilog/bstap_top.sv
// Boundary-scan test access port: state machine, instruction register,
// bypass, identification and boundary chains, and the ball drive mux.
// Assumes tck comes from the board tester and is unrelated to sys_clk;
// ring_in comes straight from the balls, core_* from sys_clk logic.
//
// Behaviour
// RULE_01: Eight-bit serial instruction register, six codes decoded.
// RULE_02: EXTEST captures ring, chain connected, balls drive chain.
// RULE_03: IDCODE loads 32-bit ID, core undisturbed.
// RULE_04: SAMPLE/PRELOAD captures ring into chain, core undisturbed.
// RULE_05: CLAMP selects bypass, balls drive chain values.
// RULE_06: HIGH-Z selects bypass, all outputs high impedance.
// RULE_07: All-ones code selects one-bit bypass register.
// RULE_08: 113 cells fixed order; bidirectional balls use two.
// RULE_09: IDCODE active at reset and test-logic-reset.
// RULE_10: Instruction shifted in Shift-IR, applied at Update-IR.
// RULE_11: ID fields revision, device, vendor; bit zero one.
// RULE_12: Chain shifts from serial input toward lowest cell.
// RULE_13: Standard state machine; output changes on falling edge.
// RULE_14: Undefined codes behave exactly like bypass.
`timescale 1ns/1ps

module bstap_top
    import bstap_pkg::*;
#(
    parameter logic [3:0]  ID_REV    = 4'h0,   // Arbitrary value.
    parameter logic [15:0] ID_DEV    = 16'h0000, // Arbitrary value.
    parameter logic [10:0] ID_VENDOR = 11'h000, // Arbitrary value.
    parameter int          N_CELLS   = BSR_LEN
) (
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic               clk_en,
    input  wire logic               tck,
    input  wire logic               tms,
    input  wire logic               tdi,
    output logic                    tdo,
    output logic                    tdo_oe,
    input  wire logic [N_CELLS-1:0] ring_in,
    input  wire logic [N_CELLS-1:0] core_out,
    input  wire logic [N_CELLS-1:0] core_oe,
    output logic      [N_CELLS-1:0] pad_out,
    output logic      [N_CELLS-1:0] pad_oe
);

    localparam logic [N_CELLS-1:0] DRIVE = N_CELLS'(bstap_drive_mask());
    localparam logic [ID_W-1:0] ID_WORD =
        (ID_W'(ID_REV) << ID_REV_LSB) | (ID_W'(ID_DEV) << ID_DEV_LSB) |
        (ID_W'(ID_VENDOR) << ID_VEN_LSB) | ID_W'(ID_PRESENT);

    // -----------------------------------------------------------------
    // Reset and enable brought into the test clock domain
    // -----------------------------------------------------------------
    logic [1:0] t_rst_sync;
    logic [1:0] t_ce_sync;
    logic       t_rst;
    logic       t_ce;

    // Two flops each; only the second stage is read by the logic.
    always_ff @(posedge tck) begin
        t_rst_sync <= {t_rst_sync[0], ~rst_n};
        t_ce_sync  <= {t_ce_sync[0], clk_en};
    end
    assign t_rst = t_rst_sync[1];
    assign t_ce  = t_ce_sync[1];

    // -----------------------------------------------------------------
    // Test state machine
    // -----------------------------------------------------------------
    bstap_state_t state;
    bstap_state_t next_state;

    // Sixteen-state walk steered by tms on rising tck.
    always_comb begin
        case (state)
            BSTAP_TLR:    next_state = tms ? BSTAP_TLR    : BSTAP_RTI;
            BSTAP_RTI:    next_state = tms ? BSTAP_SEL_DR : BSTAP_RTI;
            BSTAP_SEL_DR: next_state = tms ? BSTAP_SEL_IR : BSTAP_CAP_DR;
            BSTAP_CAP_DR: next_state = tms ? BSTAP_EX1_DR : BSTAP_SH_DR;
            BSTAP_SH_DR:  next_state = tms ? BSTAP_EX1_DR : BSTAP_SH_DR;
            BSTAP_EX1_DR: next_state = tms ? BSTAP_UPD_DR : BSTAP_PA_DR;
            BSTAP_PA_DR:  next_state = tms ? BSTAP_EX2_DR : BSTAP_PA_DR;
            BSTAP_EX2_DR: next_state = tms ? BSTAP_UPD_DR : BSTAP_SH_DR;
            BSTAP_UPD_DR: next_state = tms ? BSTAP_SEL_DR : BSTAP_RTI;
            BSTAP_SEL_IR: next_state = tms ? BSTAP_TLR    : BSTAP_CAP_IR;
            BSTAP_CAP_IR: next_state = tms ? BSTAP_EX1_IR : BSTAP_SH_IR;
            BSTAP_SH_IR:  next_state = tms ? BSTAP_EX1_IR : BSTAP_SH_IR;
            BSTAP_EX1_IR: next_state = tms ? BSTAP_UPD_IR : BSTAP_PA_IR;
            BSTAP_PA_IR:  next_state = tms ? BSTAP_EX2_IR : BSTAP_PA_IR;
            BSTAP_EX2_IR: next_state = tms ? BSTAP_UPD_IR : BSTAP_SH_IR;
            BSTAP_UPD_IR: next_state = tms ? BSTAP_SEL_DR : BSTAP_RTI;
            default:      next_state = BSTAP_TLR;
        endcase
    end

    // State register; system reset parks it in test-logic-reset.
    always_ff @(posedge tck) begin
        if (t_rst) begin
            state <= BSTAP_TLR;
        end else if (t_ce) begin
            state <= next_state; // [RULE_13]
        end
    end

    // -----------------------------------------------------------------
    // Instruction register and decode
    // -----------------------------------------------------------------
    logic [IR_W-1:0] ir_shift;
    logic [IR_W-1:0] ir_active;
    logic [IR_W-1:0] next_ir_active;
    bstap_sel_t      dr_sel;
    logic            mode_chain; // Balls driven from the update latches.
    logic            mode_highz;

    // Shift path; captures the fixed pattern so a tester sees ...01.
    always_ff @(posedge tck) begin
        if (t_rst) begin
            ir_shift <= IR_CAPTURE;
        end else if (t_ce) begin
            if (state == BSTAP_CAP_IR) begin
                ir_shift <= IR_CAPTURE;
            end else if (state == BSTAP_SH_IR) begin
                ir_shift <= {tdi, ir_shift[IR_W-1:1]}; // [RULE_01]
            end
        end
    end

    // Instruction that the coming edge makes active. Decoding this one
    // lets the ball modes leave on the Update-IR edge itself, because
    // tck may stand still right after the frame that loads them.
    always_comb begin
        next_ir_active = ir_active;
        if (state == BSTAP_TLR) begin
            next_ir_active = IR_RESET; // [RULE_09]
        end else if (state == BSTAP_UPD_IR) begin
            next_ir_active = ir_shift; // [RULE_10]
        end
    end

    // Active instruction changes only at Update-IR, test-logic-reset or reset.
    always_ff @(posedge tck) begin
        if (t_rst) begin
            ir_active <= IR_RESET; // [RULE_09]
        end else if (t_ce) begin
            ir_active <= next_ir_active;
        end
    end

    // Decode; any code not listed falls to bypass with core in control.
    // Outside Update-IR and test-logic-reset this is the active code.
    always_comb begin
        dr_sel     = BSTAP_SEL_BYPASS;
        mode_chain = 1'b0;
        mode_highz = 1'b0;
        case (next_ir_active)
            INS_EXTEST: begin
                dr_sel     = BSTAP_SEL_BSR; // [RULE_02]
                mode_chain = 1'b1;
            end
            INS_IDCODE: dr_sel = BSTAP_SEL_ID; // [RULE_03]
            INS_SAMPLE: dr_sel = BSTAP_SEL_BSR; // [RULE_04]
            INS_CLAMP:  mode_chain = 1'b1; // [RULE_05]
            INS_HIGHZ:  mode_highz = 1'b1; // [RULE_06]
            INS_BYPASS: dr_sel = BSTAP_SEL_BYPASS; // [RULE_07]
            default:    dr_sel = BSTAP_SEL_BYPASS; // [RULE_14]
        endcase
    end

    // -----------------------------------------------------------------
    // Data registers
    // -----------------------------------------------------------------
    logic               bypass_bit;
    logic [ID_W-1:0]    id_shift;
    logic [N_CELLS-1:0] ring_s1;
    logic [N_CELLS-1:0] ring_s2;
    logic [N_CELLS-1:0] bsr_shift;
    logic [N_CELLS-1:0] bsr_upd;
    logic [N_CELLS-1:0] next_bsr_upd;

    // Balls are asynchronous to tck; two flops before capture.
    // Capture still sees whatever the ball held two tck edges earlier.
    always_ff @(posedge tck) begin
        ring_s1 <= ring_in;
        ring_s2 <= ring_s1;
    end

    // Bypass cell captures zero, then passes tdi by one stage.
    always_ff @(posedge tck) begin
        if (t_rst) begin
            bypass_bit <= 1'b0;
        end else if (t_ce) begin
            if (state == BSTAP_CAP_DR) begin
                bypass_bit <= 1'b0;
            end else if (state == BSTAP_SH_DR) begin
                bypass_bit <= tdi; // [RULE_07]
            end
        end
    end

    // Identification word is loaded on capture and shifted LSB first.
    always_ff @(posedge tck) begin
        if (t_rst) begin
            id_shift <= ID_WORD;
        end else if (t_ce && dr_sel == BSTAP_SEL_ID) begin
            if (state == BSTAP_CAP_DR) begin
                id_shift <= ID_WORD; // [RULE_11] [RULE_03]
            end else if (state == BSTAP_SH_DR) begin
                id_shift <= {tdi, id_shift[ID_W-1:1]};
            end
        end
    end

    // Boundary chain: tdi enters the top cell, cell 0 exits first.
    always_ff @(posedge tck) begin
        if (t_rst) begin
            bsr_shift <= '0;
        end else if (t_ce && dr_sel == BSTAP_SEL_BSR) begin
            if (state == BSTAP_CAP_DR) begin
                bsr_shift <= ring_s2; // [RULE_02] [RULE_04] [RULE_08]
            end else if (state == BSTAP_SH_DR) begin
                bsr_shift <= {tdi, bsr_shift[N_CELLS-1:1]}; // [RULE_12]
            end
        end
    end

    // Value the update latches take at the coming edge.
    always_comb begin
        next_bsr_upd = bsr_upd;
        if (state == BSTAP_UPD_DR && dr_sel == BSTAP_SEL_BSR) begin
            next_bsr_upd = bsr_shift; // [RULE_04]
        end
    end

    // Update latches hold what the balls drive under chain modes;
    // preload through SAMPLE fills them before EXTEST is entered.
    always_ff @(posedge tck) begin
        if (t_rst) begin
            bsr_upd <= '0;
        end else if (t_ce) begin
            bsr_upd <= next_bsr_upd;
        end
    end

    // -----------------------------------------------------------------
    // Serial output on the falling edge
    // -----------------------------------------------------------------
    // Falling-edge launch gives the tester half a period of setup.
    always_ff @(negedge tck) begin
        if (t_rst) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (t_ce) begin
            tdo_oe <= (state == BSTAP_SH_DR) || (state == BSTAP_SH_IR);
            if (state == BSTAP_SH_IR) begin
                tdo <= ir_shift[0]; // [RULE_13]
            end else begin
                case (dr_sel)
                    BSTAP_SEL_ID:  tdo <= id_shift[0];
                    BSTAP_SEL_BSR: tdo <= bsr_shift[0]; // [RULE_12]
                    default:       tdo <= bypass_bit;
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // Crossing of drive values and mode into sys_clk
    // -----------------------------------------------------------------
    logic               xfer_tgl;
    logic [N_CELLS-1:0] xfer_data;
    logic               xfer_chain;
    logic               xfer_highz;

    // Bundle is held stable between updates; a toggle announces it.
    // Limitation: updates must be at least three sys_clk apart,
    // which any tck slower than sys_clk guarantees.
    always_ff @(posedge tck) begin
        if (t_rst) begin
            xfer_tgl   <= 1'b0;
            xfer_data  <= '0;
            xfer_chain <= 1'b0;
            xfer_highz <= 1'b0;
        end else if (t_ce) begin
            if (xfer_data != next_bsr_upd || xfer_chain != mode_chain ||
                xfer_highz != mode_highz) begin
                xfer_tgl   <= ~xfer_tgl;
                xfer_data  <= next_bsr_upd;
                xfer_chain <= mode_chain;
                xfer_highz <= mode_highz;
            end
        end
    end

    logic [2:0]         s_tgl;
    logic [N_CELLS-1:0] s_data;
    logic               s_chain;
    logic               s_highz;

    // Toggle synchroniser; stage 0 is read only by stage 1.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_tgl <= 3'h0;
        end else if (clk_en) begin
            s_tgl <= {s_tgl[1:0], xfer_tgl};
        end
    end

    // Bundle copied once the toggle edge has settled.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_data  <= '0;
            s_chain <= 1'b0;
            s_highz <= 1'b0;
        end else if (clk_en && (s_tgl[2] != s_tgl[1])) begin
            s_data  <= xfer_data;
            s_chain <= xfer_chain;
            s_highz <= xfer_highz;
        end
    end

    // -----------------------------------------------------------------
    // Ball drive
    // -----------------------------------------------------------------
    // Core owns the balls except under chain or high-impedance modes.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pad_out <= '0;
            pad_oe  <= '0;
        end else if (clk_en) begin
            if (s_highz) begin
                pad_out <= '0;
                pad_oe  <= '0; // [RULE_06]
            end else if (s_chain) begin
                pad_out <= s_data & DRIVE; // [RULE_02] [RULE_05]
                pad_oe  <= DRIVE; // [RULE_08]
            end else begin
                pad_out <= core_out; // [RULE_03] [RULE_07] [RULE_14]
                pad_oe  <= core_oe;
            end
        end
    end

endmodule : bstap_top
